// File: rtl/acu_analog_control.sv
`timescale 1ns/100ps
`default_nettype none
module acu_analog_control (
	input wire logic clk,
	input wire logic rst,
	input wire acu_pkg::acu_wr_t wr,
	input wire acu_pkg::acu_mode_t mode,
	input wire logic full_function,
	input wire logic crystal_running,
	input wire logic adc_base_tick,
	output logic [9:0] upper_bits,
	output logic current_adc_on,
	output logic crystal_osc_on,
	output logic crystal_kick,
	output logic crystal_divider_bypass,
	output logic crystal_low_power,
	output logic adc_sample_tick
);
	import acu_pkg::*;

	typedef struct packed {
		acu_fields_t f;
		acu_mode_t mode_prev;
		logic run_s1;
		logic run_s2;
		logic kick;
		logic [4:0] div_cnt;
		logic tick;
	} acu_state_t;

	acu_state_t s_r;
	acu_state_t s_nxt;

	function automatic logic [4:0] acu_div(input logic [1:0] sel);
		case (sel)
			2'h0: acu_div = ACU_DIV_819K;
			2'h1: acu_div = ACU_DIV_409K;
			2'h2: acu_div = ACU_DIV_204K;
			default: acu_div = ACU_DIV_102K;
		endcase
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.run_s1 = crystal_running;
		s_nxt.run_s2 = s_r.run_s1;
		s_nxt.mode_prev = mode;
		if (wr.wr_en && wr.addr == ACU_ANALOG_CONTROL_ZERO_ADDR) begin
			s_nxt.f.current_adc_enable = wr.wdata[ACU_ADC_ENABLE_BIT];
			s_nxt.f.crystal_restart_enable = wr.wdata[ACU_RESTART_BIT];
			s_nxt.f.crystal_power_down = wr.wdata[ACU_POWER_DOWN_BIT];
			s_nxt.f.crystal_divider_bypass = wr.wdata[ACU_BYPASS_BIT];
			s_nxt.f.crystal_low_power = wr.wdata[ACU_LOW_POWER_BIT];
			s_nxt.f.adc_clock_select =
				wr.wdata[ACU_CLK_SEL_LSB +: 2];
		end
		// follows crystal state
		// hardware wins over a same-cycle write so a stop is never missed
		if (mode == ACU_MODE_METER && full_function) begin
			if (!s_r.run_s2 && !s_r.f.crystal_power_down) begin
				s_nxt.f.crystal_power_down = 1'b1;
			end else if (s_r.run_s2 && s_r.f.crystal_power_down) begin
				s_nxt.f.crystal_power_down = 1'b0;
			end
		end
		if (mode != s_r.mode_prev) begin
			if (mode == ACU_MODE_SLEEP) begin
				s_nxt.f.current_adc_enable = 1'b0;
			end else if (mode == ACU_MODE_DETECT) begin
				s_nxt.f.current_adc_enable = 1'b1;
			end
		end
		s_nxt.kick = s_r.f.crystal_restart_enable && !s_r.run_s2;
		s_nxt.tick = 1'b0;
		if (adc_base_tick) begin
			if (s_r.div_cnt >= acu_div(s_r.f.adc_clock_select)) begin
				s_nxt.div_cnt = 5'h00;
				s_nxt.tick = 1'b1;
			end else begin
				s_nxt.div_cnt = s_r.div_cnt + 5'h01;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
			s_r.f.adc_clock_select <= ACU_CLK_SEL_RESET;
			s_r.mode_prev <= ACU_MODE_METER;
			// assume running so reset does not look like a crystal stop
			s_r.run_s1 <= 1'b1;
			s_r.run_s2 <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// reserved bits 23:22 and 15 always read zero
	assign upper_bits = {s_r.f.current_adc_enable, 2'h0,
		s_r.f.crystal_restart_enable, s_r.f.crystal_power_down,
		s_r.f.crystal_divider_bypass, s_r.f.crystal_low_power,
		s_r.f.adc_clock_select, 1'b0};
	assign current_adc_on = s_r.f.current_adc_enable;
	assign crystal_osc_on = !s_r.f.crystal_power_down;
	assign crystal_kick = s_r.kick;
	assign crystal_divider_bypass = s_r.f.crystal_divider_bypass;
	assign crystal_low_power = s_r.f.crystal_low_power;
	assign adc_sample_tick = s_r.tick;
endmodule
`default_nettype wire

// File: rtl/acu_pkg.sv
// Summary of operation
// - a one in current_adc_enable turns the current ADC on; resets to 0.
// - current_adc_enable clears on sleep entry, sets on detect entry.
// - with crystal_restart_enable set, a stopped crystal is stimulated.
// - a one in crystal_power_down stops the oscillator; resets to 0.
// - in full metering crystal_power_down follows crystal stop/resume.
// - adc_clock_select picks 819.2/409.6/204.8/102.4 kHz; resets to 00.
`default_nettype none
package acu_pkg;
	localparam logic [15:0] ACU_ANALOG_CONTROL_ZERO_ADDR = 16'h0185;
	localparam int ACU_ADC_ENABLE_BIT = 24;
	localparam int ACU_RESTART_BIT = 21;
	localparam int ACU_POWER_DOWN_BIT = 20;
	localparam int ACU_BYPASS_BIT = 19;
	localparam int ACU_LOW_POWER_BIT = 18;
	localparam int ACU_CLK_SEL_LSB = 16;
	localparam logic [1:0] ACU_CLK_SEL_RESET = 2'h0;
	// adc clock division from a 3.2768 MHz metering base: 4, 8, 16, 32
	localparam logic [4:0] ACU_DIV_819K = 5'h03;
	localparam logic [4:0] ACU_DIV_409K = 5'h07;
	localparam logic [4:0] ACU_DIV_204K = 5'h0F;
	localparam logic [4:0] ACU_DIV_102K = 5'h1F;

	typedef enum logic [1:0] {
		ACU_MODE_METER,
		ACU_MODE_SLEEP,
		ACU_MODE_DETECT
	} acu_mode_t;

	typedef struct packed {
		logic current_adc_enable;
		logic crystal_restart_enable;
		logic crystal_power_down;
		logic crystal_divider_bypass;
		logic crystal_low_power;
		logic [1:0] adc_clock_select;
	} acu_fields_t;

	typedef struct packed {
		logic wr_en;
		logic [15:0] addr;
		logic [31:0] wdata;
	} acu_wr_t;
endpackage
`default_nettype wire

// File: testbench/acu_chk.sv
`timescale 1ns/100ps
`default_nettype none
module acu_chk (
	input wire logic clk, rst, full_function, crystal_running, adc_base_tick,
	input wire acu_pkg::acu_wr_t wr,
	input wire acu_pkg::acu_mode_t mode,
	input wire logic [9:0] upper_bits,
	input wire logic current_adc_on, crystal_osc_on, crystal_kick,
	input wire logic crystal_divider_bypass, crystal_low_power, adc_sample_tick
);
	import acu_pkg::*;
	wire logic [9:0] u = upper_bits;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ****
	// checks
	// ****
	chk_sleep_clr: assert property ($changed(mode) &&
		mode == ACU_MODE_SLEEP |=> !current_adc_on) else $error("sleep");
	chk_detect_set: assert property ($changed(mode) &&
		mode == ACU_MODE_DETECT |=> current_adc_on) else $error("detect");
	chk_adc_write: assert property (wr.wr_en && !$changed(mode) &&
		wr.addr == ACU_ANALOG_CONTROL_ZERO_ADDR |=>
		current_adc_on == $past(wr.wdata[24])) else $error("adc write");
	chk_resv_zero: assert property ({u[8:7], u[0]} == 3'h0)
		else $error("reserved");
	chk_osc_inv: assert property (crystal_osc_on != u[5]) else $error("osc");
	chk_field_copy: assert property ({crystal_divider_bypass,
		crystal_low_power} == u[4:3]) else $error("copy");
	chk_kick_stop: assert property ((u[6] && !crystal_running) [*4]
		|=> crystal_kick) else $error("kick");
	chk_tick_gap: assert property (adc_sample_tick && u[2:1] == 2'h0
		|=> !adc_sample_tick [*3]) else $error("tick");
	cover property (crystal_kick);
	cover property ($rose(current_adc_on));
	cover property (adc_sample_tick && u[2:1] == 2'h3);
endmodule
bind acu_analog_control acu_chk acu_chk_inst (.*);
`default_nettype wire

// File: testbench/acu_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
	$display("unexpected %s exp %0h got %0h", n, e, s); end end
module testbench;
	import acu_pkg::*;
	logic clk = 0, rst = 1, full_function = 0, crystal_running = 1;
	logic current_adc_on, crystal_osc_on, crystal_kick, adc_sample_tick;
	logic crystal_divider_bypass, crystal_low_power, adc_base_tick = 1;
	logic [9:0] upper_bits;
	acu_wr_t wr = '0;
	acu_mode_t mode = ACU_MODE_METER;
	int errors = 0, cmp_count = 0, cyc = 0;
	logic [7:0] n;
	acu_analog_control acu_analog_control_inst (.*);
	// ****
	// helpers
	// ****
	initial forever #2 clk = ~clk;
	// run is about 500 cycles; the ceiling leaves ample slack
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			errors++;
			test_done;
		end
	end
	task tk(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task wreg(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk) wr <= '{1'b1, a, d};
		@(posedge clk) wr.wr_en <= 1'b0;
		#1;
	endtask
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task t_write;
		`CK("reset", 11'h001, {upper_bits, crystal_osc_on})
		// current ADC on, reserved bits zero, every crystal bit set, 102.4 kHz adc clock
		wreg(ACU_ANALOG_CONTROL_ZERO_ADDR, 32'h093F_0000);
		`CK("fields", 11'h4FC, {upper_bits, crystal_osc_on})
		`CK("copies", 3'h7, {crystal_divider_bypass, crystal_low_power,
			current_adc_on})
		wreg(16'h0186, '0);
		`CK("unmapped", 10'h27E, upper_bits)
		$display("write test end");
	endtask
	task t_mode;
		@(posedge clk) mode <= ACU_MODE_SLEEP;
		tk(2);
		`CK("sleep", 1'b0, current_adc_on)
		@(posedge clk) mode <= ACU_MODE_DETECT;
		tk(2);
		`CK("detect", 1'b1, current_adc_on)
		wreg(ACU_ANALOG_CONTROL_ZERO_ADDR, 32'h093E_0000);
		`CK("detect rate", 2'h2, upper_bits[2:1])
		@(posedge clk) mode <= ACU_MODE_METER;
		$display("mode test end");
	endtask
	task t_xtal;
		wreg(ACU_ANALOG_CONTROL_ZERO_ADDR, 32'h0020_0000);
		@(posedge clk) {full_function, crystal_running} <= 2'h2;
		tk(5);
		`CK("stopped", 2'h3, {crystal_kick, upper_bits[5]})
		@(posedge clk) crystal_running <= 1'b1;
		tk(5);
		`CK("resumed", 2'h0, {crystal_kick, upper_bits[5]})
		$display("crystal test end");
	endtask
	task t_rate;
		// slow rates are only legal outside full metering
		@(posedge clk) full_function <= 1'b0;
		for (int s = 0; s < 4; s++) begin
			wreg(ACU_ANALOG_CONTROL_ZERO_ADDR, 32'(s) << 16);
			tk(40);
			n = 0;
			repeat (64) @(posedge clk) #1 n += adc_sample_tick;
			`CK("ticks", 16 >> s, n)
		end
		$display("rate test end");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		tk(1);
		t_write;
		t_mode;
		t_xtal;
		t_rate;
		test_done;
	end
endmodule
`default_nettype wire
